/* File: bst_defs.vh */
`ifndef BST_DEFS_VH
`define BST_DEFS_VH
// TAP controller states
`define BST_S_RESET 4'h0
`define BST_S_IDLE 4'h1
`define BST_S_SEL_DR 4'h2
`define BST_S_CAP_DR 4'h3
`define BST_S_SHF_DR 4'h4
`define BST_S_EX1_DR 4'h5
`define BST_S_PAU_DR 4'h6
`define BST_S_EX2_DR 4'h7
`define BST_S_UPD_DR 4'h8
`define BST_S_SEL_IR 4'h9
`define BST_S_CAP_IR 4'hA
`define BST_S_SHF_IR 4'hB
`define BST_S_EX1_IR 4'hC
`define BST_S_PAU_IR 4'hD
`define BST_S_EX2_IR 4'hE
`define BST_S_UPD_IR 4'hF
// Instruction register
`define BST_IR_W 3
`define BST_IR_CAP_PAT 2'h1
// Default instruction codes
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE_Z 3'h2
`define BST_OP_SAMPLE 3'h4
`define BST_OP_BYPASS 3'h7
// Identification register
`define BST_ID_W 32
`define BST_ID_VALUE 32'h0000_0001
// Boundary chain
`define BST_BSR_LEN 109
`define BST_BSR_OE_BIT 108
`endif

/* File: bst_tap.v */
// What this block does
// - TMS and TDI sampled on TCK rise; TDO changes only on TCK fall.
// - Serial data enters each scan register at MSB, leaves at LSB.
// - Current instruction selects which data register sits between TDI and TDO.
// - TDO driven only in shift states; otherwise high impedance.
// - Five TCK rises with TMS high reset the TAP, memory unaffected.
// - Power-up reset puts TAP in reset with TDO released.
// - At most one scan register connects TDI to TDO at a time.
// - Instruction register loads identification code at power up and TAP reset.
// - Capture-IR loads 01 into the two low instruction bits.
// - Bypass register is one bit, cleared when bypass executes.
// - Boundary chain has one cell per pin plus reserved no-connect cells.
// - Capture-DR loads pin ring into chain; Shift-DR shifts it.
// - Extest, sample/preload and sample-Z select the boundary chain.
// - Identification instruction captures hardwired 32-bit value in Capture-DR.
// - Identification instruction shifts that value out in Shift-DR.
// - Instruction shifted in Shift-IR takes effect only at Update-IR.
// - Sample-Z holds the output bus in high impedance until next instruction.
// - Extest drives preloaded boundary values onto system output pins.
// - Chain bit 108 enables output bus under extest; presets high on reset.
// - Bypass instruction puts the one-bit bypass register in the shift path.
`timescale 1ns/1ps
`include "bst_defs.vh"
module bst_tap #(
  parameter BSR_LEN = `BST_BSR_LEN,
  parameter [`BST_IR_W-1:0] OP_EXTEST = `BST_OP_EXTEST,
  parameter [`BST_IR_W-1:0] OP_IDCODE = `BST_OP_IDCODE,
  parameter [`BST_IR_W-1:0] OP_SAMPLE_Z = `BST_OP_SAMPLE_Z,
  parameter [`BST_IR_W-1:0] OP_SAMPLE = `BST_OP_SAMPLE,
  parameter [`BST_IR_W-1:0] OP_BYPASS = `BST_OP_BYPASS,
  // Arbitrary identification value
  parameter [`BST_ID_W-1:0] ID_VALUE = `BST_ID_VALUE
) (
  input wire clk,
  input wire srst,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire [BSR_LEN-1:0] pin_ring,
  output reg tdo_o,
  output reg tdo_oe,
  output reg [BSR_LEN-1:0] bsr_update_ff,
  output reg extest_drive_ff,
  output reg out_bus_hiz_ff
);
  // ----------------------------------------
  // Pin synchronisers and TCK edges
  // ----------------------------------------
  reg [1:0] tck_sync_ff;
  reg [1:0] tms_sync_ff;
  reg [1:0] tdi_sync_ff;
  reg tck_prev_ff;
  wire tck_rise;
  wire tck_fall;
  always @(posedge clk) begin
    if (srst) begin
      tck_sync_ff <= 2'h0;
      tms_sync_ff <= 2'h3;
      tdi_sync_ff <= 2'h3;
      tck_prev_ff <= 1'b0;
    end else begin
      tck_sync_ff <= {tck_sync_ff[0], tck};
      tms_sync_ff <= {tms_sync_ff[0], tms};
      tdi_sync_ff <= {tdi_sync_ff[0], tdi};
      tck_prev_ff <= tck_sync_ff[1];
    end
  end
  assign tck_rise = tck_sync_ff[1] & ~tck_prev_ff;
  assign tck_fall = ~tck_sync_ff[1] & tck_prev_ff;
  wire tms_s = tms_sync_ff[1];
  wire tdi_s = tdi_sync_ff[1];

  // ----------------------------------------
  // Pin ring synchroniser
  // ----------------------------------------
  reg [BSR_LEN-1:0] ring_meta_ff;
  reg [BSR_LEN-1:0] ring_sync_ff;
  always @(posedge clk) begin
    if (srst) begin
      ring_meta_ff <= {BSR_LEN{1'b0}};
      ring_sync_ff <= {BSR_LEN{1'b0}};
    end else begin
      ring_meta_ff <= pin_ring;
      ring_sync_ff <= ring_meta_ff;
    end
  end

  // ----------------------------------------
  // TAP state machine
  // ----------------------------------------
  localparam [3:0] S_RESET = `BST_S_RESET;
  localparam [3:0] S_IDLE = `BST_S_IDLE;
  localparam [3:0] S_SEL_DR = `BST_S_SEL_DR;
  localparam [3:0] S_CAP_DR = `BST_S_CAP_DR;
  localparam [3:0] S_SHF_DR = `BST_S_SHF_DR;
  localparam [3:0] S_EX1_DR = `BST_S_EX1_DR;
  localparam [3:0] S_PAU_DR = `BST_S_PAU_DR;
  localparam [3:0] S_EX2_DR = `BST_S_EX2_DR;
  localparam [3:0] S_UPD_DR = `BST_S_UPD_DR;
  localparam [3:0] S_SEL_IR = `BST_S_SEL_IR;
  localparam [3:0] S_CAP_IR = `BST_S_CAP_IR;
  localparam [3:0] S_SHF_IR = `BST_S_SHF_IR;
  localparam [3:0] S_EX1_IR = `BST_S_EX1_IR;
  localparam [3:0] S_PAU_IR = `BST_S_PAU_IR;
  localparam [3:0] S_EX2_IR = `BST_S_EX2_IR;
  localparam [3:0] S_UPD_IR = `BST_S_UPD_IR;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  always @* begin
    case (state_ff)
      S_RESET: nxt_state = tms_s ? S_RESET : S_IDLE;
      S_IDLE: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_DR: nxt_state = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: nxt_state = tms_s ? S_EX1_DR : S_SHF_DR;
      S_SHF_DR: nxt_state = tms_s ? S_EX1_DR : S_SHF_DR;
      S_EX1_DR: nxt_state = tms_s ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: nxt_state = tms_s ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: nxt_state = tms_s ? S_UPD_DR : S_SHF_DR;
      S_UPD_DR: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_IR: nxt_state = tms_s ? S_RESET : S_CAP_IR;
      S_CAP_IR: nxt_state = tms_s ? S_EX1_IR : S_SHF_IR;
      S_SHF_IR: nxt_state = tms_s ? S_EX1_IR : S_SHF_IR;
      S_EX1_IR: nxt_state = tms_s ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: nxt_state = tms_s ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: nxt_state = tms_s ? S_UPD_IR : S_SHF_IR;
      S_UPD_IR: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
      default: nxt_state = S_RESET;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_ff <= S_RESET;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  // Entering or staying in reset, whatever the path
  wire enter_reset = tck_rise & (nxt_state == S_RESET);

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  function op_is;
    input [`BST_IR_W-1:0] cur;
    input [`BST_IR_W-1:0] code;
    begin
      op_is = (cur == code);
    end
  endfunction

  reg [`BST_IR_W-1:0] ir_shift_ff;
  reg [`BST_IR_W-1:0] ir_ff;
  wire sel_ext = op_is(ir_ff, OP_EXTEST);
  wire sel_hiz = op_is(ir_ff, OP_SAMPLE_Z);
  wire sel_bsr = sel_ext | op_is(ir_ff, OP_SAMPLE) | sel_hiz;
  wire sel_id = op_is(ir_ff, OP_IDCODE);
  // Reserved codes fall back to bypass
  wire sel_byp = ~sel_bsr & ~sel_id;

  always @(posedge clk) begin
    if (srst) begin
      ir_shift_ff <= OP_IDCODE;
      ir_ff <= OP_IDCODE;
    end else if (tck_rise) begin
      if (state_ff == S_CAP_IR)
        ir_shift_ff <= {ir_ff[`BST_IR_W-1], `BST_IR_CAP_PAT};
      else if (state_ff == S_SHF_IR)
        ir_shift_ff <= {tdi_s, ir_shift_ff[`BST_IR_W-1:1]};
      if (enter_reset)
        ir_ff <= OP_IDCODE;
      else if (state_ff == S_UPD_IR)
        ir_ff <= ir_shift_ff;
    end
  end

  // ----------------------------------------
  // Scan registers
  // ----------------------------------------
  reg [`BST_ID_W-1:0] id_shift_ff;
  reg [BSR_LEN-1:0] bsr_shift_ff;
  reg byp_ff;

  always @(posedge clk) begin
    if (srst) begin
      id_shift_ff <= {`BST_ID_W{1'b0}};
    end else if (tck_rise & sel_id) begin
      if (state_ff == S_CAP_DR)
        id_shift_ff <= ID_VALUE;
      else if (state_ff == S_SHF_DR)
        id_shift_ff <= {tdi_s, id_shift_ff[`BST_ID_W-1:1]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      bsr_shift_ff <= {BSR_LEN{1'b0}};
    end else if (tck_rise & sel_bsr) begin
      if (state_ff == S_CAP_DR)
        bsr_shift_ff <= ring_sync_ff;
      else if (state_ff == S_SHF_DR)
        bsr_shift_ff <= {tdi_s, bsr_shift_ff[BSR_LEN-1:1]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      byp_ff <= 1'b0;
    end else if (tck_rise & sel_byp) begin
      if (state_ff == S_CAP_DR)
        byp_ff <= 1'b0;
      else if (state_ff == S_SHF_DR)
        byp_ff <= tdi_s;
    end
  end

  // ----------------------------------------
  // Preload latches
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      bsr_update_ff <= {BSR_LEN{1'b0}};
      bsr_update_ff[`BST_BSR_OE_BIT] <= 1'b1;
    end else if (tck_rise) begin
      if (enter_reset)
        bsr_update_ff[`BST_BSR_OE_BIT] <= 1'b1;
      else if ((state_ff == S_UPD_DR) & sel_bsr)
        bsr_update_ff <= bsr_shift_ff;
    end
  end

  // ----------------------------------------
  // TDO on falling TCK
  // ----------------------------------------
  reg nxt_tdo;
  always @* begin
    if (state_ff == S_SHF_IR)
      nxt_tdo = ir_shift_ff[0];
    else if (sel_id)
      nxt_tdo = id_shift_ff[0];
    else if (sel_bsr)
      nxt_tdo = bsr_shift_ff[0];
    else
      nxt_tdo = byp_ff;
  end
  wire shifting = (state_ff == S_SHF_IR) | (state_ff == S_SHF_DR);

  always @(posedge clk) begin
    if (srst) begin
      tdo_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= shifting ? nxt_tdo : 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= shifting;
    end
  end

  // ----------------------------------------
  // System pin control
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      extest_drive_ff <= 1'b0;
    end else begin
      extest_drive_ff <= sel_ext;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      out_bus_hiz_ff <= 1'b0;
    end else begin
      out_bus_hiz_ff <= sel_hiz | (sel_ext & ~bsr_update_ff[`BST_BSR_OE_BIT]);
    end
  end
endmodule // bst_tap

/* File: bst_tap_asserts.sv */
`timescale 1ns/1ps
module bst_tap_asserts #(
  parameter BSR_LEN = 109
) (
  input wire clk,
  input wire srst,
  input wire tck,
  input wire tms,
  input wire tdo_o,
  input wire tdo_oe,
  input wire [BSR_LEN-1:0] bsr_update_ff,
  input wire extest_drive_ff,
  input wire out_bus_hiz_ff
);
  reg [2:0] tck_ff, tms_ff, cnt_ff;
  // ----------------------------------------
  // Count of tck rises with tms high
  // ----------------------------------------
  always @(posedge clk) begin
    tck_ff <= {tck_ff[1:0], tck};
    tms_ff <= {tms_ff[1:0], tms};
    if (srst) cnt_ff <= 3'h0;
    else if (tck_ff[1] && !tck_ff[2]) cnt_ff <= !tms_ff[1] ? 3'h0 : (cnt_ff == 3'h5) ? 3'h5 : cnt_ff + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_tdo_on_fall: assert property (($changed(tdo_o) || $changed(tdo_oe)) |-> !$past(tck, 2))
    else $error("tdo changed outside tck low");
  chk_tdo_stands: assert property ($changed(tdo_oe) |=> $stable(tdo_oe) [*6])
    else $error("tdo enable did not hold");
  chk_tdo_released: assert property (!tdo_oe |-> !tdo_o)
    else $error("tdo data while released");
  chk_reset_state: assert property ($fell(srst) |-> !tdo_oe && !extest_drive_ff && bsr_update_ff == {1'b1, {(BSR_LEN-1){1'b0}}})
    else $error("bad state after power-up reset");
  chk_tms_reset: assert property ($rose(cnt_ff == 3'h5) |-> ##[0:4] (!extest_drive_ff && !tdo_oe && bsr_update_ff[BSR_LEN-1]))
    else $error("five tms-high rises did not reset");
  chk_extest_hiz: assert property (extest_drive_ff && !bsr_update_ff[BSR_LEN-1] |-> ##[0:1] out_bus_hiz_ff)
    else $error("output bus not released");
  chk_upd_on_rise: assert property ($changed(bsr_update_ff) |-> $past(tck, 2))
    else $error("preload latched off a tck rise");
  chk_ir_on_rise: assert property (($changed(extest_drive_ff) || $changed(out_bus_hiz_ff)) |-> $past(tck, 2))
    else $error("instruction effect off a tck rise");
endmodule // bst_tap_asserts
bind bst_tap bst_tap_asserts #(.BSR_LEN(BSR_LEN)) u_chk (.clk, .srst, .tck, .tms, .tdo_o, .tdo_oe,
  .bsr_update_ff, .extest_drive_ff, .out_bus_hiz_ff);

/* File: bst_tst_model.sv */
`timescale 1ns/1ps
module bst_tst_model (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  logic seen;
  initial begin
    tck = 0;
    tms = 1;
    tdi = 1;
    seen = 1;
  end
  // ----------------------------------------
  // One tck period, tck still between calls
  // ----------------------------------------
  task step(input logic [1:0] md);
    @(negedge clk) {tms, tdi} = md;
    repeat (7) @(negedge clk);
    tck = 1;
    seen = tdo_oe ? tdo_o : ~seen;
    repeat (8) @(negedge clk);
    tck = 0;
  endtask
  task shift(input int n, input logic [108:0] din, output logic [108:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step({i == n - 1, din[i]});
      dout[i] = seen;
    end
  endtask
  task load_ir(input logic [2:0] op, output logic [2:0] cap);
    logic [108:0] q;
    step(2'h3); step(2'h3); step(2'h1); step(2'h1);
    shift(3, {106'h0, op}, q);
    step(2'h3); step(2'h1);
    cap = q[2:0];
  endtask
  task scan_dr(input int n, input logic [108:0] din, output logic [108:0] dout);
    step(2'h3); step(2'h1); step(2'h1);
    shift(n, din, dout);
    step(2'h3); step(2'h1);
  endtask
  task reset5;
    repeat (5) step(2'h3);
  endtask
endmodule // bst_tst_model

/* File: bst_tap_tb.sv */
`timescale 1ns/1ps
`include "bst_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module bst_tap_tb;
  typedef struct {logic [2:0] op; int n; logic [108:0] din, exp; logic ext, hiz;} bst_row_t;
  localparam logic [108:0] RING = {13'h1ABC, 32'h5A5AC3C3, 64'h0123456789ABCDEF};
  localparam logic [108:0] PRE = {1'h1, 108'hF00D};
  localparam logic [108:0] DRV = {1'h0, 108'hBEEF};
  localparam logic [108:0] RST = {1'h1, 108'h0};
  localparam logic [108:0] RSTD = {1'h1, 108'hBEEF};
  logic clk, srst, tck, tms, tdi, tdo_o, tdo_oe, extest_drive_ff, out_bus_hiz_ff;
  logic [108:0] pin_ring, bsr_update_ff, cap;
  logic [2:0] ir_cap, prev;
  int err_total, num_checks;
  bst_row_t rows [5] = '{
    '{`BST_OP_IDCODE, 32, '0, 109'(`BST_ID_VALUE), 1'b0, 1'b0},
    '{`BST_OP_BYPASS, 4, 109'hA, 109'h4, 1'b0, 1'b0},
    '{`BST_OP_SAMPLE_Z, 109, '0, RING, 1'b0, 1'b1},
    '{`BST_OP_SAMPLE, 109, PRE, RING, 1'b0, 1'b0},
    '{`BST_OP_EXTEST, 109, DRV, RING, 1'b1, 1'b1}};
  bst_tst_model u_tst (.clk, .tck, .tms, .tdi, .tdo_o, .tdo_oe);
  bst_tap u_dut (.clk, .srst, .tck, .tms, .tdi, .pin_ring, .tdo_o, .tdo_oe, .bsr_update_ff,
    .extest_drive_ff, .out_bus_hiz_ff);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task conclude;
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1;
    pin_ring = RING;
    err_total = 0;
    num_checks = 0;
    prev = `BST_OP_IDCODE;
    repeat (6) @(negedge clk);
    srst = 0;
    `CHK("oe_after_reset", 1'b0, tdo_oe)
    `CHK("preload_after_reset", RST, bsr_update_ff)
    u_tst.step(2'h1);
    foreach (rows[i]) begin
      u_tst.load_ir(rows[i].op, ir_cap);
      `CHK("ir_capture", {prev[2], 2'b01}, ir_cap)
      u_tst.scan_dr(rows[i].n, rows[i].din, cap);
      `CHK("scan_out", rows[i].exp, cap)
      `CHK("drive", rows[i].ext, extest_drive_ff)
      `CHK("hiz", rows[i].hiz, out_bus_hiz_ff)
      `CHK("tdo_idle", 1'b0, tdo_oe)
      prev = rows[i].op;
    end
    `CHK("preload", DRV, bsr_update_ff)
    u_tst.reset5();
    `CHK("reset_drive", 1'b0, extest_drive_ff)
    `CHK("reset_preload", RSTD, bsr_update_ff)
    @(negedge clk) srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    `CHK("srst_preload", RST, bsr_update_ff)
    `CHK("srst_oe", 1'b0, tdo_oe)
    u_tst.step(2'h1);
    u_tst.scan_dr(32, '0, cap);
    `CHK("id_after_reset", 109'(`BST_ID_VALUE), cap)
    conclude;
  end
endmodule // bst_tap_tb
